// File: hw/ddrlt_pkg.sv
// Package with constants and types of the DDR read latency host controller.
package ddrlt_pkg;

  // ****************************************************************
  // Command opcodes
  // ****************************************************************
  localparam logic [7:0] OP_FAST_DDR_3B = 8'h0D;
  localparam logic [7:0] OP_FAST_DDR_4B = 8'h0E;
  localparam logic [7:0] OP_DUAL_DDR_3B = 8'hBD;
  localparam logic [7:0] OP_DUAL_DDR_4B = 8'hBE;
  localparam logic [7:0] OP_QUAD_DDR_3B = 8'hED;
  localparam logic [7:0] OP_QUAD_DDR_4B = 8'hEE;

  // ****************************************************************
  // Latency codes, frequency limits and table values
  // ****************************************************************
  localparam logic [1:0] LC_00 = 2'h0;
  localparam logic [1:0] LC_01 = 2'h1;
  localparam logic [1:0] LC_10 = 2'h2;
  localparam logic [1:0] LC_11 = 2'h3;
  localparam int LC_HIGH_POS = 7;
  localparam int LC_LOW_POS = 6;
  localparam logic [7:0] FMAX_LC11_MHZ = 8'h32;
  localparam logic [7:0] FMAX_OTHER_MHZ = 8'h42;
  localparam logic [3:0] MODE_FAST = 4'h4;
  localparam logic [3:0] MODE_DUAL = 4'h2;
  localparam logic [3:0] MODE_QUAD = 4'h1;
  localparam logic [3:0] LAT_FAST_11 = 4'h1;
  localparam logic [3:0] LAT_DUAL_11 = 4'h2;
  localparam logic [3:0] LAT_QUAD_11 = 4'h3;
  localparam logic [3:0] LAT_FAST_00 = 4'h2;
  localparam logic [3:0] LAT_DUAL_00 = 4'h4;
  localparam logic [3:0] LAT_QUAD_00 = 4'h6;
  localparam logic [3:0] LAT_FAST_01 = 4'h4;
  localparam logic [3:0] LAT_DUAL_01 = 4'h5;
  localparam logic [3:0] LAT_QUAD_01 = 4'h7;
  localparam logic [3:0] LAT_FAST_10 = 4'h5;
  localparam logic [3:0] LAT_DUAL_10 = 4'h6;
  localparam logic [3:0] LAT_QUAD_10 = 4'h8;

  // ****************************************************************
  // Identification map walking
  // ****************************************************************
  localparam logic [7:0] PAD_PARAM_ID = 8'hF0;
  localparam logic [7:0] PAD_PARAM_LEN = 8'h0F;
  localparam logic [7:0] PAD_FILL = 8'hFF;

  // ****************************************************************
  // Serial clock divider and reset values
  // ****************************************************************
  localparam int SCK_HALF_CYCLES = 2;
  localparam logic [7:0] SCK_MHZ = 8'h0A;
  localparam logic [7:0] MODE_BITS_RST = 8'hA5;

  typedef enum logic [1:0] {
    DDRLT_FAST = 2'h0,
    DDRLT_DUAL = 2'h1,
    DDRLT_QUAD = 2'h2
  } ddrlt_kind_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_LAT = 8'h10,
    ST_DATA = 8'h20,
    ST_DONE = 8'h40,
    ST_ERR = 8'h80
  } ddrlt_state_t;

endpackage

// File: hw/ddrlt_lat_table.sv
// Lookup of mode and latency cycle counts for the DDR read commands.
`timescale 1ns/1ps
module ddrlt_lat_table (
  // Selection
  input wire logic [1:0] latency_code_in,
  input wire logic [1:0] kind_in,
  input wire logic [7:0] sck_mhz_in,
  // Result
  output logic [3:0] mode_cycles_out,
  output logic [3:0] lat_cycles_out,
  output logic supported_out
);

  always_comb begin
    mode_cycles_out = ddrlt_pkg::MODE_FAST;
    lat_cycles_out = ddrlt_pkg::LAT_FAST_00;
    supported_out = 1'b1;
    case (kind_in)
      ddrlt_pkg::DDRLT_DUAL: mode_cycles_out = ddrlt_pkg::MODE_DUAL;
      ddrlt_pkg::DDRLT_QUAD: mode_cycles_out = ddrlt_pkg::MODE_QUAD;
      default: mode_cycles_out = ddrlt_pkg::MODE_FAST;
    endcase
    case (latency_code_in)
      ddrlt_pkg::LC_11: begin
        supported_out = (sck_mhz_in <= ddrlt_pkg::FMAX_LC11_MHZ);
        case (kind_in)
          ddrlt_pkg::DDRLT_DUAL: lat_cycles_out = ddrlt_pkg::LAT_DUAL_11;
          ddrlt_pkg::DDRLT_QUAD: lat_cycles_out = ddrlt_pkg::LAT_QUAD_11;
          default: lat_cycles_out = ddrlt_pkg::LAT_FAST_11;
        endcase
      end
      ddrlt_pkg::LC_00: begin
        supported_out = (sck_mhz_in <= ddrlt_pkg::FMAX_OTHER_MHZ);
        case (kind_in)
          ddrlt_pkg::DDRLT_DUAL: lat_cycles_out = ddrlt_pkg::LAT_DUAL_00;
          ddrlt_pkg::DDRLT_QUAD: lat_cycles_out = ddrlt_pkg::LAT_QUAD_00;
          default: lat_cycles_out = ddrlt_pkg::LAT_FAST_00;
        endcase
      end
      ddrlt_pkg::LC_01: begin
        supported_out = (sck_mhz_in <= ddrlt_pkg::FMAX_OTHER_MHZ);
        case (kind_in)
          ddrlt_pkg::DDRLT_DUAL: lat_cycles_out = ddrlt_pkg::LAT_DUAL_01;
          ddrlt_pkg::DDRLT_QUAD: lat_cycles_out = ddrlt_pkg::LAT_QUAD_01;
          default: lat_cycles_out = ddrlt_pkg::LAT_FAST_01;
        endcase
      end
      default: begin
        supported_out = (sck_mhz_in <= ddrlt_pkg::FMAX_OTHER_MHZ);
        case (kind_in)
          ddrlt_pkg::DDRLT_DUAL: lat_cycles_out = ddrlt_pkg::LAT_DUAL_10;
          ddrlt_pkg::DDRLT_QUAD: lat_cycles_out = ddrlt_pkg::LAT_QUAD_10;
          default: lat_cycles_out = ddrlt_pkg::LAT_FAST_10;
        endcase
      end
    endcase
  end

endmodule // ddrlt_lat_table

// File: hw/ddrlt_host.sv
// Host controller issuing DDR reads and walking the identification map.
// Functional notes
// - Code 11b, <=50MHz: fast four mode, one latency
// - Code 11b: dual 2/2, quad 1/3 cycles
// - Code 00b, <=66MHz: fast four mode, two latency
// - Code 00b: dual 2/4, quad 1/6 cycles
// - Code 01b, <=66MHz: fast four mode, four latency
// - Code 01b: dual 2/5, quad 1/7 cycles
// - Code 10b, <=66MHz: fast four mode, five latency
// - Code 10b: dual 2/6, quad 1/8 cycles
// - Next parameter at length location plus length plus one
// - Padding may repeat; reader skips every one
`timescale 1ns/1ps
module ddrlt_host (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Read request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire logic [1:0] req_kind_in,
  input wire logic req_addr4_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [7:0] req_len_in,
  input wire logic [7:0] config_reg_in,
  // Map walk: current parameter header seen by the caller
  input wire logic [7:0] map_id_in,
  input wire logic [7:0] map_len_in,
  input wire logic [15:0] map_len_loc_in,
  output logic [15:0] map_next_loc_out,
  output logic map_is_pad_out,
  // Read data
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic err_out,
  // Serial pins
  output logic sck_out,
  output logic cs_n_out,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ddrlt_pkg::ddrlt_state_t st;
    logic [1:0] div;
    logic sck;
    logic [1:0] kind;
    logic addr4;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic [5:0] bits;
    logic [3:0] cnt;
    logic [3:0] mode;
    logic [3:0] lat;
    logic [7:0] len;
    logic [7:0] sh;
    logic [3:0] io;
    logic [3:0] oe;
    logic [7:0] data;
    logic dv;
    logic done;
    logic err;
    logic [3:0] sync1;
    logic [3:0] sync2;
  } ddrlt_host_t;

  ddrlt_host_t r;
  ddrlt_host_t next_r;
  logic [3:0] tbl_mode;
  logic [3:0] tbl_lat;
  logic tbl_ok;
  logic [1:0] lc;

  assign lc = {config_reg_in[ddrlt_pkg::LC_HIGH_POS],
               config_reg_in[ddrlt_pkg::LC_LOW_POS]};

  ddrlt_lat_table u_table (
    .latency_code_in(lc),
    .kind_in(req_kind_in),
    .sck_mhz_in(ddrlt_pkg::SCK_MHZ),
    .mode_cycles_out(tbl_mode),
    .lat_cycles_out(tbl_lat),
    .supported_out(tbl_ok)
  );

  // ****************************************************************
  // Map walk
  // ****************************************************************
  // The next header is always found by the length byte, so every padding
  // parameter is skipped whatever its length.
  assign map_next_loc_out = map_len_loc_in + {8'h00, map_len_in} + 16'h0001;
  assign map_is_pad_out = (map_id_in == ddrlt_pkg::PAD_PARAM_ID);

  assign req_ready_out = (r.st == ddrlt_pkg::ST_IDLE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    logic rise;
    logic edge_any;
    logic [3:0] lanes;
    logic [7:0] op;
    rise = 1'b0;
    op = 8'h00;
    edge_any = 1'b0;
    lanes = 4'h1;
    next_r = r;
    next_r.dv = 1'b0;
    next_r.done = 1'b0;
    next_r.sync1 = io_in;
    next_r.sync2 = r.sync1;
    case (r.kind)
      ddrlt_pkg::DDRLT_DUAL: lanes = 4'h2;
      ddrlt_pkg::DDRLT_QUAD: lanes = 4'h4;
      default: lanes = 4'h1;
    endcase
    if (r.st != ddrlt_pkg::ST_IDLE && r.st != ddrlt_pkg::ST_DONE && r.st != ddrlt_pkg::ST_ERR) begin
      if (r.div == 2'(ddrlt_pkg::SCK_HALF_CYCLES - 1)) begin
        next_r.div = 2'h0;
        edge_any = 1'b1;
        rise = ~r.sck;
        next_r.sck = ~r.sck;
      end else begin
        next_r.div = r.div + 2'h1;
      end
    end
    case (r.st)
      ddrlt_pkg::ST_IDLE: begin
        next_r.sck = 1'b0;
        next_r.div = 2'h0;
        next_r.oe = 4'h0;
        if (req_valid_in) begin
          next_r.kind = req_kind_in;
          next_r.addr4 = req_addr4_in;
          next_r.addr = req_addr_in;
          next_r.len = req_len_in;
          next_r.mode = tbl_mode;
          next_r.lat = tbl_lat;
          case (req_kind_in)
            ddrlt_pkg::DDRLT_DUAL: op = req_addr4_in ? ddrlt_pkg::OP_DUAL_DDR_4B
                                                     : ddrlt_pkg::OP_DUAL_DDR_3B;
            ddrlt_pkg::DDRLT_QUAD: op = req_addr4_in ? ddrlt_pkg::OP_QUAD_DDR_4B
                                                     : ddrlt_pkg::OP_QUAD_DDR_3B;
            default: op = req_addr4_in ? ddrlt_pkg::OP_FAST_DDR_4B
                                       : ddrlt_pkg::OP_FAST_DDR_3B;
          endcase
          // The first command bit is set up before the first rising edge.
          next_r.io = {3'h0, op[7]};
          next_r.cmd = {op[6:0], 1'b0};
          next_r.err = 1'b0;
          next_r.st = tbl_ok ? ddrlt_pkg::ST_CMD : ddrlt_pkg::ST_ERR;
          next_r.bits = 6'd7;
          next_r.oe = tbl_ok ? 4'h1 : 4'h0;
        end
      end
      ddrlt_pkg::ST_CMD: begin
        // Command goes out one bit per falling edge on the single lane.
        if (edge_any && !rise && r.bits != 6'd0) begin
          next_r.io = {3'h0, r.cmd[7]};
          next_r.cmd = {r.cmd[6:0], 1'b0};
          next_r.bits = r.bits - 6'd1;
        end else if (edge_any && rise && r.bits == 6'd0) begin
          // Last bit has been taken; address starts on the next falling edge.
          next_r.st = ddrlt_pkg::ST_ADDR;
          next_r.bits = r.addr4 ? 6'd32 : 6'd24;
          if (!r.addr4) next_r.addr = {r.addr[23:0], 8'h00};
        end
      end
      ddrlt_pkg::ST_ADDR: begin
        // Address moves on both edges, lanes bits at a time.
        if (edge_any) begin
          next_r.oe = (lanes == 4'h4) ? 4'hF : (lanes == 4'h2) ? 4'h3 : 4'h1;
          if (lanes == 4'h4) begin
            next_r.io = r.addr[31:28];
            next_r.addr = {r.addr[27:0], 4'h0};
          end else if (lanes == 4'h2) begin
            next_r.io = {2'h0, r.addr[31:30]};
            next_r.addr = {r.addr[29:0], 2'h0};
          end else begin
            next_r.io = {3'h0, r.addr[31]};
            next_r.addr = {r.addr[30:0], 1'b0};
          end
          next_r.bits = r.bits - 6'(lanes);
          if (r.bits == 6'(lanes)) begin
            next_r.st = ddrlt_pkg::ST_MODE;
            next_r.cnt = 4'h0;
          end
        end
      end
      ddrlt_pkg::ST_MODE: begin
        // Each mode value stands one full serial clock before release.
        if (edge_any && !rise) begin
          if (r.cnt == r.mode) begin
            next_r.st = ddrlt_pkg::ST_LAT;
            next_r.cnt = 4'h0;
            next_r.oe = 4'h0;
          end else begin
            next_r.io = ddrlt_pkg::MODE_BITS_RST[3:0];
            next_r.cnt = r.cnt + 4'h1;
          end
        end
      end
      ddrlt_pkg::ST_LAT: begin
        next_r.oe = 4'h0;
        if (edge_any && !rise) begin
          next_r.cnt = r.cnt + 4'h1;
          if (r.cnt + 4'h1 == r.lat) begin
            next_r.st = ddrlt_pkg::ST_DATA;
            next_r.bits = 6'd8;
          end
        end
      end
      ddrlt_pkg::ST_DATA: begin
        // Data is taken on both serial clock edges only after latency ends.
        if (edge_any) begin
          if (lanes == 4'h4) next_r.sh = {r.sh[3:0], r.sync2};
          else if (lanes == 4'h2) next_r.sh = {r.sh[5:0], r.sync2[1:0]};
          else next_r.sh = {r.sh[6:0], r.sync2[1]};
          next_r.bits = r.bits - 6'(lanes);
          if (r.bits == 6'(lanes)) begin
            next_r.data = next_r.sh;
            next_r.dv = 1'b1;
            next_r.bits = 6'd8;
            next_r.len = r.len - 8'h01;
            if (r.len == 8'h01) next_r.st = ddrlt_pkg::ST_DONE;
          end
        end
      end
      ddrlt_pkg::ST_DONE: begin
        next_r.sck = 1'b0;
        next_r.done = 1'b1;
        next_r.st = ddrlt_pkg::ST_IDLE;
      end
      ddrlt_pkg::ST_ERR: begin
        next_r.err = 1'b1;
        next_r.done = 1'b1;
        next_r.st = ddrlt_pkg::ST_IDLE;
      end
      default: next_r.st = ddrlt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.st <= ddrlt_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data_out = r.data;
  assign rd_valid_out = r.dv;
  assign done_out = r.done;
  assign err_out = r.err;
  assign sck_out = r.sck;
  assign cs_n_out = (r.st == ddrlt_pkg::ST_IDLE) || (r.st == ddrlt_pkg::ST_DONE)
                    || (r.st == ddrlt_pkg::ST_ERR);
  assign io_out = r.io;
  assign io_oe_out = r.oe;

endmodule // ddrlt_host

// File: sim/ddrlt_host_properties.sv
// Port checker of the DDR read host controller.
`timescale 1ns/1ps
module ddrlt_host_properties (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Request and map walk
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic [7:0] map_id_in,
  input wire logic [7:0] map_len_in,
  input wire logic [15:0] map_len_loc_in,
  input wire logic [15:0] map_next_loc_out,
  input wire logic map_is_pad_out,
  // Data and serial pins
  input wire logic rd_valid_out,
  input wire logic done_out,
  input wire logic sck_out,
  input wire logic cs_n_out,
  input wire logic [3:0] io_oe_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    req_valid_in && req_ready_out;
  endsequence
  sequence s_quiet_start;
    (!rd_valid_out && !done_out) [*8];
  endsequence
  a_next_loc_sum: assert property (map_next_loc_out == map_len_loc_in + map_len_in + 16'h1)
    else $error("next location wrong");
  a_pad_detect: assert property (map_is_pad_out == (map_id_in == 8'hF0))
    else $error("padding flag wrong");
  a_take_opens_frame: assert property (s_take |=> !cs_n_out && !req_ready_out)
    else $error("frame did not open");
  a_sck_half_period: assert property ($changed(sck_out) |=> $stable(sck_out))
    else $error("serial clock too fast");
  a_idle_no_drive: assert property (cs_n_out |-> io_oe_out == 4'h0 && !sck_out)
    else $error("pins active while idle");
  a_no_early_data: assert property (s_take |=> s_quiet_start)
    else $error("data before latency");
  a_valid_one_cycle: assert property (rd_valid_out |-> io_oe_out == 4'h0 ##1 !rd_valid_out)
    else $error("data while driving");
  a_done_then_ready: assert property (done_out |=> !done_out && req_ready_out)
    else $error("done not followed by ready");
endmodule // ddrlt_host_properties

// File: sim/ddrlt_flash_model.sv
// Behavioural serial flash that answers the DDR read commands.
`timescale 1ns/1ps
module ddrlt_flash_model (
  // Clock and pins
  input wire logic clk_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] io_drv_in,
  input wire logic [3:0] io_oe_in,
  input wire logic [7:0] config_in,
  output logic [3:0] io_wire_out,
  // Observations
  output logic [7:0] op_out,
  output logic [31:0] addr_out,
  output logic [3:0] mode_seen_out
);
  logic [3:0] dev_q;
  logic [3:0] dev_en;
  logic [3:0] junk = 4'h5;
  logic [3:0] mask;
  logic [7:0] byt;
  logic [3:0] io_prev;
  logic [3:0] oe_prev;
  int lanes;
  int nlat;
  int b;
  // Latency for codes 00b, 01b, 10b, 11b.
  int lat_fast[4] = '{2, 4, 5, 1};
  int lat_dual[4] = '{4, 5, 6, 2};
  int lat_quad[4] = '{6, 7, 8, 3};
  // Released lanes toggle every cycle so that stale data never looks valid.
  always @(posedge clk_in) junk <= ~junk;
  // Lanes are read as they stood before the edge, since the host may change them on it.
  always @(posedge clk_in) begin
    io_prev <= io_wire_out;
    oe_prev <= io_oe_in;
  end
  assign io_wire_out = (io_oe_in & io_drv_in) | (~io_oe_in & ((dev_en & dev_q) | (~dev_en & junk)));
  task automatic frame();
    op_out = 8'h00;
    addr_out = 32'h0;
    mode_seen_out = 4'h0;
    repeat (8) begin
      @(posedge sck_in);
      op_out = {op_out[6:0], io_prev[0]};
    end
    lanes = (op_out == 8'hBD || op_out == 8'hBE) ? 2 : (op_out[7:4] == 4'hE) ? 4 : 1;
    mask = 4'((1 << lanes) - 1);
    nlat = lanes == 1 ? lat_fast[config_in[7:6]] : lanes == 2 ? lat_dual[config_in[7:6]] : lat_quad[config_in[7:6]];
    for (int i = 0; i < ((op_out[3:0] == 4'hE) ? 32 : 24) / lanes; i++) begin
      if (i % 2 == 0) @(posedge sck_in);
      else @(negedge sck_in);
      addr_out = (addr_out << lanes) | 32'(io_prev & mask);
    end
    repeat (4 / lanes + nlat) begin
      @(posedge sck_in);
      if (oe_prev != 4'h0) mode_seen_out = mode_seen_out + 4'h1;
    end
    // Data is presented one edge early to cover the host's input synchroniser.
    dev_en = (lanes == 1) ? 4'h2 : mask;
    b = 0;
    forever begin
      byt = addr_out[7:0] + 8'(b / 8);
      dev_q = 4'(byt >> (8 - lanes - b % 8)) & mask;
      if (lanes == 1) dev_q = {2'b00, dev_q[0], 1'b0};
      b = b + lanes;
      @(sck_in);
    end
  endtask
  initial begin
    dev_en = 4'h0;
    dev_q = 4'h0;
    forever begin
      @(negedge cs_n_in);
      fork
        frame();
        @(posedge cs_n_in);
      join_any
      disable fork;
      dev_en = 4'h0;
    end
  end
endmodule // ddrlt_flash_model

// File: sim/ddrlt_host_bench.sv
// Self-checking bench of the DDR read host controller against a flash model.
`timescale 1ns/1ps
module ddrlt_host_bench;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic [1:0] req_kind_in = 2'h0;
  logic req_addr4_in = 1'b0;
  logic [31:0] req_addr_in = 32'h0;
  logic [7:0] req_len_in = 8'h01;
  logic [7:0] config_reg_in = 8'h00;
  logic [7:0] map_id_in = 8'h00;
  logic [7:0] map_len_in = 8'h00;
  logic [15:0] map_len_loc_in = 16'h0;
  logic [15:0] map_next_loc_out;
  logic [7:0] rd_data_out, seen_op;
  logic [31:0] seen_addr;
  logic [3:0] io_in, io_out, io_oe_out, seen_mode;
  logic req_ready_out, map_is_pad_out, rd_valid_out, done_out, err_out, sck_out, cs_n_out;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  ddrlt_host ddrlt_host_inst (.clk_sys_in, .sys_rst_in, .req_valid_in, .req_ready_out,
    .req_kind_in, .req_addr4_in, .req_addr_in, .req_len_in, .config_reg_in, .map_id_in,
    .map_len_in, .map_len_loc_in, .map_next_loc_out, .map_is_pad_out, .rd_data_out,
    .rd_valid_out, .done_out, .err_out, .sck_out, .cs_n_out, .io_in, .io_out, .io_oe_out);
  ddrlt_flash_model ddrlt_flash_model_inst (.clk_in(clk_sys_in), .cs_n_in(cs_n_out),
    .sck_in(sck_out), .io_drv_in(io_out), .io_oe_in(io_oe_out), .config_in(config_reg_in),
    .io_wire_out(io_in), .op_out(seen_op), .addr_out(seen_addr), .mode_seen_out(seen_mode));
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic do_read(input logic [1:0] kind, input logic addr4, input logic [31:0] addr,
      input logic [7:0] len, input logic [1:0] lc);
    logic [7:0] op;
    int n;
    n = 0;
    op = kind == 2'h0 ? (addr4 ? ddrlt_pkg::OP_FAST_DDR_4B : ddrlt_pkg::OP_FAST_DDR_3B) :
      kind == 2'h1 ? (addr4 ? ddrlt_pkg::OP_DUAL_DDR_4B : ddrlt_pkg::OP_DUAL_DDR_3B) :
      (addr4 ? ddrlt_pkg::OP_QUAD_DDR_4B : ddrlt_pkg::OP_QUAD_DDR_3B);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    req_kind_in <= kind;
    req_addr4_in <= addr4;
    req_addr_in <= addr;
    req_len_in <= len;
    // Low bits are set so that only bits 7:6 may steer the latency.
    config_reg_in <= {lc, 6'h15};
    do @(negedge clk_sys_in); while (req_ready_out !== 1'b1);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    repeat (6000) begin
      @(negedge clk_sys_in);
      if (rd_valid_out === 1'b1) begin
        check(rd_data_out, addr[7:0] + n);
        n = n + 1;
      end
      if (done_out === 1'b1) break;
    end
    check(n, len);
    check(err_out, 1'b0);
    check(seen_op, op);
    check(seen_addr, addr4 ? addr : {8'h00, addr[23:0]});
    check(seen_mode, kind == 2'h0 ? 4 : kind == 2'h1 ? 2 : 1);
  endtask
  task automatic test_fast_rows();
    for (int c = 0; c < 4; c++) do_read(2'h0, c[0], 32'h8712_3440 + c, 8'h03, 2'(c));
  endtask
  task automatic test_dual_rows();
    for (int c = 0; c < 4; c++) do_read(2'h1, c[0], 32'h5A00_1120 + c, 8'h05, 2'(c));
  endtask
  task automatic test_quad_rows();
    for (int c = 0; c < 4; c++) do_read(2'h2, c[0], 32'hC3FE_0010 + c, 8'h01 + 8'(c * 60), 2'(c));
  endtask
  task automatic map_case(input logic [7:0] id, input logic [7:0] len, input logic [15:0] loc);
    logic [15:0] exp_loc;
    exp_loc = loc + len + 16'h1;
    @(posedge clk_sys_in);
    map_id_in <= id;
    map_len_in <= len;
    map_len_loc_in <= loc;
    @(negedge clk_sys_in);
    check(map_next_loc_out, exp_loc);
    check(map_is_pad_out, id == ddrlt_pkg::PAD_PARAM_ID);
  endtask
  task automatic test_map_walk();
    map_case(8'hF0, 8'h0F, 16'h002D);
    map_case(8'hF0, 8'h03, 16'h003D);
    map_case(8'h9A, 8'h2A, 16'h0001);
    map_case(8'hF0, 8'h0F, 16'hFFF2);
  endtask
  task automatic test_reset_mid();
    @(posedge clk_sys_in);
    req_valid_in <= 1'b1;
    repeat (60) @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    sys_rst_in <= 1'b1;
    @(negedge clk_sys_in);
    check({cs_n_out, sck_out, io_oe_out}, 6'h20);
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    do_read(2'h2, 1'b1, 32'hA1B2_C350, 8'h04, 2'h2);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    test_fast_rows();
    test_dual_rows();
    test_quad_rows();
    test_map_walk();
    test_reset_mid();
    wrap_up();
  end
endmodule // ddrlt_host_bench
bind ddrlt_host ddrlt_host_properties ddrlt_host_properties_inst (.clk_sys_in, .sys_rst_in,
  .req_valid_in, .req_ready_out, .map_id_in, .map_len_in, .map_len_loc_in, .map_next_loc_out,
  .map_is_pad_out, .rd_valid_out, .done_out, .sck_out, .cs_n_out, .io_oe_out);
